// ### rtl/ebirs_top.sv
`include "ebirs_regs.svh"
module ebirs_top #(
  parameter int          CLK_DIV    = `EBIRS_CLK_DIV,
  parameter int          NUM_WORDS  = 8,
  parameter int          NUM_CH     = 4,
  // Default identity values are arbitrary
  parameter logic [15:0] DEF_VENDOR = 16'h1234,
  parameter logic [15:0] DEF_SUBVEN = 16'h5678
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              soft_reset,
  // Serial memory pins
  output logic                   nvm_serial_clock,
  output logic                   nvm_select_o,
  output logic                   nvm_select_oe,
  input  wire logic              nvm_select_i,
  output logic                   nvm_write_data,
  input  wire logic              nvm_read_data,
  // Strap pin
  input  wire logic              infrared_strap,
  // Manual control register
  input  wire logic              man_wr,
  input  wire logic [2:0]        man_wdata,
  output logic      [3:0]        nvm_manual_control_reg,
  // Load status and identity
  output logic                   load_done,
  output logic                   nvm_present,
  output logic      [15:0]       vendor_id,
  output logic      [15:0]       subvendor_id,
  input  wire logic [2:0]        word_addr,
  output logic      [15:0]       word_data,
  // Modem control infrared bit, all channels
  output logic      [NUM_CH-1:0] mcr_ir_bit,
  output logic                   mcr_ir_load
);
  localparam int HALF = CLK_DIV / 2;
  localparam int DW   = $clog2(HALF);

  initial begin
    if (CLK_DIV < 4 || CLK_DIV % 2 != 0 || NUM_WORDS != 8 || NUM_CH < 1) begin
      $error("ebirs_top: unsupported parameter values");
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic strap_m, strap_s, do_m, do_s, csin_m, csin_s;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {strap_m, strap_s, do_m, do_s, csin_m, csin_s} <= 6'h00;
    end else begin
      strap_m <= infrared_strap;
      strap_s <= strap_m;
      do_m    <= nvm_read_data;
      do_s    <= do_m;
      csin_m  <= nvm_select_i;
      csin_s  <= csin_m;
    end
  end

  // ****************************************
  // Settle timer after reset or soft reset
  // ****************************************
  logic [1:0] wait_r;
  logic       sample;

  assign sample = (wait_r == 2'd1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_r <= `EBIRS_SETTLE;
    end else if (soft_reset) begin
      wait_r <= `EBIRS_SETTLE;
    end else if (wait_r != 2'd0) begin
      wait_r <= wait_r - 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mcr_ir_bit  <= '0;
      mcr_ir_load <= 1'b0;
    end else begin
      mcr_ir_load <= sample;
      if (sample) begin
        mcr_ir_bit <= {NUM_CH{strap_s}};
      end
    end
  end

  // ****************************************
  // Serial clock divider
  // ****************************************
  logic [DW-1:0] div_r;
  logic          tick;

  assign tick = (div_r == DW'(HALF - 1));

  always_ff @(posedge clk) begin
    if (!nrst || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ****************************************
  // Loader state machine
  // ****************************************
  ebirs_pkg::ebirs_state_t state_r;
  logic [2:0]  word_r;
  logic [4:0]  bit_r;
  logic [8:0]  cmd_r;
  logic [15:0] shift_r;
  logic [3:0]  wcnt_r;
  logic        sk_r, cs_r, cs_oe_r, di_r, present_r;
  logic        mem_we;
  logic [15:0] mem_wdata;

  assign mem_we    = tick && sk_r && (state_r == ebirs_pkg::ST_READ)
                     && (bit_r == `EBIRS_WORD_BITS - 5'd1);
  assign mem_wdata = {shift_r[14:0], do_s};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r   <= ebirs_pkg::ST_SENSE;
      word_r    <= 3'd0;
      bit_r     <= 5'd0;
      cmd_r     <= 9'h000;
      shift_r   <= 16'h0000;
      sk_r      <= 1'b0;
      cs_r      <= 1'b0;
      cs_oe_r   <= 1'b0;
      di_r      <= 1'b0;
      present_r <= 1'b0;
    end else begin
      unique case (state_r)
        ebirs_pkg::ST_SENSE: begin
          if (sample) begin
            present_r <= csin_s;
            cs_oe_r   <= 1'b1;
            cs_r      <= 1'b0;
            state_r   <= csin_s ? ebirs_pkg::ST_GAP : ebirs_pkg::ST_DONE;
          end
        end
        ebirs_pkg::ST_CMD: begin
          if (tick) begin
            sk_r <= !sk_r;
            if (sk_r) begin
              if (bit_r == `EBIRS_CMD_BITS - 5'd1) begin
                bit_r   <= 5'd0;
                state_r <= ebirs_pkg::ST_READ;
              end else begin
                bit_r <= bit_r + 5'd1;
                di_r  <= cmd_r[7];
                cmd_r <= {cmd_r[7:0], 1'b0};
              end
            end
          end
        end
        // sixteen bits, sampled at end of high phase
        ebirs_pkg::ST_READ: begin
          if (tick) begin
            sk_r <= !sk_r;
            di_r <= 1'b0;
            if (sk_r) begin
              shift_r <= mem_wdata;
              bit_r   <= bit_r + 5'd1;
              if (mem_we) begin
                bit_r   <= 5'd0;
                cs_r    <= 1'b0;
                word_r  <= word_r + 3'd1;
                state_r <= (word_r == 3'(NUM_WORDS - 1)) ? ebirs_pkg::ST_DONE
                                                          : ebirs_pkg::ST_GAP;
              end
            end
          end
        end
        // Select low for one half period between words
        ebirs_pkg::ST_GAP: begin
          if (tick) begin
            cs_r    <= 1'b1;
            cmd_r   <= {`EBIRS_READ_OP, 3'b000, word_r};
            di_r    <= 1'b1;
            state_r <= ebirs_pkg::ST_CMD;
          end
        end
        ebirs_pkg::ST_DONE: begin
          if (man_wr) begin
            sk_r <= man_wdata[`EBIRS_MAN_CK];
            cs_r <= man_wdata[`EBIRS_MAN_CS];
            di_r <= man_wdata[`EBIRS_MAN_DI];
          end
        end
      endcase
    end
  end

  // Write count kept for load checking
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wcnt_r <= 4'd0;
    end else if (mem_we) begin
      wcnt_r <= wcnt_r + 4'd1;
    end
  end

  // ****************************************
  // Identity words and registered outputs
  // ****************************************
  ebirs_mem #(.DEPTH(8), .WIDTH(16), .AW(3)) u_mem (
    .clk     (clk),
    .we      (mem_we),
    .waddr   (word_r),
    .wdata   (mem_wdata),
    .raddr   (word_addr),
    .rdata_r (word_data)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vendor_id    <= DEF_VENDOR;
      subvendor_id <= DEF_SUBVEN;
    end else if (mem_we) begin
      if (word_r == `EBIRS_VENDOR_WORD) begin
        vendor_id <= mem_wdata;
      end
      if (word_r == `EBIRS_SUBVEN_WORD) begin
        subvendor_id <= mem_wdata;
      end
    end
  end

  assign nvm_serial_clock = sk_r;
  assign nvm_select_o     = cs_r;
  assign nvm_select_oe    = cs_oe_r;
  assign nvm_write_data   = di_r;
  assign nvm_present      = present_r;

  // read data visible in manual register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nvm_manual_control_reg <= `EBIRS_MAN_RST;
      load_done              <= 1'b0;
    end else begin
      nvm_manual_control_reg <= {do_s, di_r, cs_r, sk_r};
      load_done              <= (state_r == ebirs_pkg::ST_DONE);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_div_clock;
    @(posedge clk) disable iff (!nrst)
      (state_r != ebirs_pkg::ST_DONE) && $changed(sk_r) |-> $past(tick);
  endproperty
  a_div_clock: assert property (p_div_clock) else $error("serial clock off divider");

  property p_id_load;
    @(posedge clk) disable iff (!nrst)
      $changed(vendor_id) |-> $past(mem_we) && ($past(word_r) == `EBIRS_VENDOR_WORD);
  endproperty
  a_id_load: assert property (p_id_load) else $error("vendor id changed without load");

  property p_man_clk;
    @(posedge clk) disable iff (!nrst)
      (state_r == ebirs_pkg::ST_DONE) && man_wr |=> sk_r == $past(man_wdata[0]);
  endproperty
  a_man_clk: assert property (p_man_clk) else $error("manual clock not applied");

  property p_man_cs;
    @(posedge clk) disable iff (!nrst)
      (state_r == ebirs_pkg::ST_DONE) && man_wr |=> cs_r == $past(man_wdata[1]) && cs_oe_r;
  endproperty
  a_man_cs: assert property (p_man_cs) else $error("manual select not applied");

  property p_man_data;
    @(posedge clk) disable iff (!nrst)
      (state_r == ebirs_pkg::ST_DONE) && man_wr |=> di_r == $past(man_wdata[2])
        ##1 nvm_manual_control_reg[`EBIRS_MAN_DI] == $past(di_r);
  endproperty
  a_man_data: assert property (p_man_data) else $error("manual data path wrong");

  property p_sense;
    @(posedge clk) disable iff (!nrst)
      (state_r == ebirs_pkg::ST_SENSE) && sample |=> present_r == $past(csin_s);
  endproperty
  a_sense: assert property (p_sense) else $error("presence sense wrong");

  property p_strap;
    @(posedge clk) disable iff (!nrst)
      sample |=> mcr_ir_load && (mcr_ir_bit == {NUM_CH{$past(strap_s)}});
  endproperty
  a_strap: assert property (p_strap) else $error("strap not copied");

  property p_soft;
    @(posedge clk) disable iff (!nrst)
      soft_reset ##1 !soft_reset [*3] |=> mcr_ir_load;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset did not resample");

  property p_words;
    @(posedge clk) disable iff (!nrst)
      $rose(load_done) && present_r |-> wcnt_r == 4'd8;
  endproperty
  a_words: assert property (p_words) else $error("word count wrong");

  property p_idle;
    @(posedge clk) disable iff (!nrst)
      $rose(load_done) && !present_r |-> !sk_r && !cs_r && cs_oe_r && wcnt_r == 4'd0;
  endproperty
  a_idle: assert property (p_idle) else $error("absent memory not idle");

  property p_no_early;
    @(posedge clk) disable iff (!nrst)
      (state_r == ebirs_pkg::ST_SENSE) && man_wr |=> !sk_r && !cs_r;
  endproperty
  a_no_early: assert property (p_no_early) else $error("manual write before load");

  c_load: cover property (@(posedge clk) disable iff (!nrst) $rose(load_done) && present_r);
  c_absent: cover property (@(posedge clk) disable iff (!nrst) $rose(load_done) && !present_r);
  c_ir: cover property (@(posedge clk) disable iff (!nrst) mcr_ir_load && mcr_ir_bit[0]);
  c_man: cover property (@(posedge clk) disable iff (!nrst) load_done && man_wr);
endmodule

// ### common/ebirs_regs.svh
`ifndef EBIRS_REGS_SVH
`define EBIRS_REGS_SVH

// Timing
`define EBIRS_CLK_DIV      256
`define EBIRS_SETTLE       2'd3
// Serial read command: start bit, read opcode, six address bits
`define EBIRS_READ_OP      3'b110
`define EBIRS_CMD_BITS     5'd9
`define EBIRS_WORD_BITS    5'd16
// Word positions inside the memory image
`define EBIRS_VENDOR_WORD  3'd0
`define EBIRS_SUBVEN_WORD  3'd1
// Manual control register fields
`define EBIRS_MAN_CK       0
`define EBIRS_MAN_CS       1
`define EBIRS_MAN_DI       2
`define EBIRS_MAN_DO       3
`define EBIRS_MAN_RST      4'h0
// Modem control register infrared bit
`define EBIRS_MCR_IR_BIT   6
`endif

// ### common/ebirs_pkg.sv
package ebirs_pkg;
  typedef enum logic [2:0] {
    ST_SENSE,
    ST_CMD,
    ST_READ,
    ST_GAP,
    ST_DONE
  } ebirs_state_t;
endpackage

// ### rtl/ebirs_mem.sv
module ebirs_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             clk,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port, data registered
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_r
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_r <= mem[raddr];
  end
endmodule

// ### sim/ebirs_nvm_model.sv
// ****************************************
// Serial memory and select line on the board
// ****************************************
module ebirs_nvm_model (
  // Memory pins
  input  wire logic sk,
  input  wire logic sel_drive,
  input  wire logic sel_en,
  input  wire logic di,
  output logic      dout,
  // Board fit and resolved select line
  input  wire logic fitted,
  output logic      sel_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0]  nbit  = 5'h0;
  logic [7:0]  cmd   = 8'h0;
  logic [15:0] shreg = 16'h0;
  logic        rd    = 1'b0;
  logic [8:0]  cmd_nxt;
  initial dout = 1'b0;
  assign sel_level = sel_en ? sel_drive : fitted;
  assign cmd_nxt   = {cmd, di};
  // four-wire read decode
  // Start, opcode 10, six address bits, dummy 0, then D15 first
  always @(posedge sk or negedge sel_level) begin
    if (!sel_level || !fitted) begin
      nbit <= 5'h0;
      rd   <= 1'b0;
      // Released output flips so a stale level cannot pass for data
      dout <= ~dout;
    end else if (rd) begin
      dout  <= shreg[15];
      shreg <= {shreg[14:0], 1'b0};
    end else begin
      cmd  <= cmd_nxt[7:0];
      nbit <= nbit + 5'h1;
      if (nbit == 5'h8 && cmd_nxt[8:6] == 3'h6) begin
        rd    <= 1'b1;
        dout  <= 1'b0;
        shreg <= {cmd_nxt[2:0], ~cmd_nxt[2:0], 10'h2d9};
      end else begin
        dout <= ~dout;
      end
    end
  end
endmodule

// ### sim/ebirs_top_tb_top.sv
// ****************************************
// Loader and strap bench
// ****************************************
module ebirs_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DIV = 8;
  logic        clk            = 1'b0;
  logic        nrst           = 1'b0;
  logic        soft_reset     = 1'b0;
  logic        man_wr         = 1'b0;
  logic [2:0]  man_wdata      = 3'h0;
  logic        infrared_strap = 1'b0;
  logic        fitted         = 1'b0;
  logic [2:0]  word_addr      = 3'h0;
  logic        nvm_serial_clock, nvm_select_o, nvm_select_oe, sel_level;
  logic        nvm_write_data, nvm_read_data, load_done, nvm_present, mcr_ir_load;
  logic [3:0]  nvm_manual_control_reg, mcr_ir_bit;
  logic [15:0] vendor_id, subvendor_id, word_data;
  int          num_errors, cmp_count, rises, frames, bad_per, hi_cnt;
  logic        sk_d, sel_d;

  ebirs_top #(.CLK_DIV(DIV)) u_dut (
    .clk                    (clk),
    .nrst                   (nrst),
    .soft_reset             (soft_reset),
    .nvm_serial_clock       (nvm_serial_clock),
    .nvm_select_o           (nvm_select_o),
    .nvm_select_oe          (nvm_select_oe),
    .nvm_select_i           (sel_level),
    .nvm_write_data         (nvm_write_data),
    .nvm_read_data          (nvm_read_data),
    .infrared_strap         (infrared_strap),
    .man_wr                 (man_wr),
    .man_wdata              (man_wdata),
    .nvm_manual_control_reg (nvm_manual_control_reg),
    .load_done              (load_done),
    .nvm_present            (nvm_present),
    .vendor_id              (vendor_id),
    .subvendor_id           (subvendor_id),
    .word_addr              (word_addr),
    .word_data              (word_data),
    .mcr_ir_bit             (mcr_ir_bit),
    .mcr_ir_load            (mcr_ir_load)
  );

  ebirs_nvm_model u_nvm (
    .sk        (nvm_serial_clock),
    .sel_drive (nvm_select_o),
    .sel_en    (nvm_select_oe),
    .di        (nvm_write_data),
    .dout      (nvm_read_data),
    .fitted    (fitted),
    .sel_level (sel_level)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Serial clock high phases and select frames seen on the pins
  always @(posedge clk) begin
    sk_d  <= nvm_serial_clock;
    sel_d <= nvm_select_o & nvm_select_oe;
    if (nvm_serial_clock) hi_cnt++;
    if (nvm_serial_clock && !sk_d) rises++;
    if (!nvm_serial_clock && sk_d && hi_cnt != DIV / 2) bad_per++;
    if (!nvm_serial_clock) hi_cnt = 0;
    if (nvm_select_o && nvm_select_oe && !sel_d) frames++;
  end

  // Stored word as laid out in the model
  function automatic logic [15:0] img(input logic [2:0] a);
    return {a, ~a, 10'h2d9};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic wait_on(input logic pulse);
    int n;
    n = 0;
    while ((pulse ? mcr_ir_load : load_done) !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n == 4000) begin
      $display("wrong value wait expected 1 seen 0");
      num_errors++;
      finish_test();
    end
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    chk("reset outputs", 16'h0000, 16'({nvm_serial_clock, nvm_select_o, nvm_select_oe,
        nvm_write_data, load_done, mcr_ir_bit, nvm_manual_control_reg}));
    rises   = 0;
    frames  = 0;
    bad_per = 0;
    nrst    = 1'b1;
  endtask

  task automatic t_absent();
    fitted         = 1'b0;
    infrared_strap = 1'b0;
    do_reset();
    wait_on(1'b0);
    repeat (4 * DIV) @(negedge clk);
    chk("present", 16'h0000, 16'(nvm_present));
    chk("vendor", 16'h1234, vendor_id);
    chk("subvendor", 16'h5678, subvendor_id);
    chk("clock rises", 16'h0000, 16'(rises));
    chk("select clock", 16'h0000, 16'({nvm_select_o, nvm_serial_clock}));
    chk("ir bits", 16'h0000, 16'(mcr_ir_bit));
    $display("test absent done");
  endtask

  task automatic t_load();
    fitted         = 1'b1;
    infrared_strap = 1'b1;
    do_reset();
    // Manual write while the loader still runs must be dropped
    man_wdata = 3'h7;
    man_wr    = 1'b1;
    @(negedge clk);
    man_wr = 1'b0;
    wait_on(1'b1);
    chk("ir bits", 16'h000f, 16'(mcr_ir_bit));
    wait_on(1'b0);
    chk("present", 16'h0001, 16'(nvm_present));
    chk("clock rises", 16'h00c8, 16'(rises));
    chk("frames", 16'h0008, 16'(frames));
    chk("high phase", 16'h0000, 16'(bad_per));
    chk("vendor", img(3'h0), vendor_id);
    chk("subvendor", img(3'h1), subvendor_id);
    for (int a = 0; a < 8; a++) begin
      word_addr = 3'(a);
      repeat (2) @(negedge clk);
      chk("word", img(3'(a)), word_data);
    end
    chk("dropped write", 16'h0000, 16'({nvm_manual_control_reg[2:0], nvm_select_o,
        nvm_serial_clock}));
    $display("test load done");
  endtask

  task automatic t_soft();
    infrared_strap = 1'b0;
    soft_reset     = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    wait_on(1'b1);
    chk("ir bits", 16'h0000, 16'(mcr_ir_bit));
    chk("vendor", img(3'h0), vendor_id);
    $display("test soft done");
  endtask

  task automatic t_manual();
    man_wr    = 1'b1;
    man_wdata = 3'h3;
    @(negedge clk);
    man_wdata = 3'h1;
    chk("oe select clock", 16'h0007, 16'({nvm_select_oe, nvm_select_o,
        nvm_serial_clock}));
    @(negedge clk);
    man_wr = 1'b0;
    chk("readback", 16'h0003, 16'(nvm_manual_control_reg[2:0]));
    chk("oe select clock", 16'h0005, 16'({nvm_select_oe, nvm_select_o,
        nvm_serial_clock}));
    man_wr    = 1'b1;
    man_wdata = 3'h4;
    @(negedge clk);
    man_wr = 1'b0;
    chk("data select clock", 16'h0004, 16'({nvm_write_data, nvm_select_o,
        nvm_serial_clock}));
    repeat (4) @(negedge clk);
    chk("data readback", 16'h0004, 16'(nvm_manual_control_reg[2:0]));
    chk("read data", 16'(nvm_read_data), 16'(nvm_manual_control_reg[3]));
    $display("test manual done");
  endtask

  initial begin
    t_absent();
    t_load();
    t_soft();
    t_manual();
    finish_test();
  end
endmodule
